/* rtl/pmi_ctrl.sv */
// Purpose: per-channel phy-mac interface control with apb control and status registers
// Assumes: analog detect circuitry runs on its own clock and holds its result levels until the next start
// Notes: apb answers in the access cycle; unmapped addresses answer pslverr
`timescale 1ns/1ps
`include "pmi_defines.svh"
module pmi_ctrl #(
    parameter bit GEN2_CAPABLE = 1'b1,
    parameter int IDLE_MIN_CYC = `PMI_IDLE_MIN_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // mac side controls
    input wire logic [1:0] power_sel,
    input wire logic force_idle,
    input wire logic detect_loopback,
    input wire logic force_disp,
    input wire logic [15:0] tx_data,
    input wire logic [1:0] tx_is_k,
    // mac side completion
    output logic done,
    output logic [2:0] status,
    // transmitter buffer and encoder side
    output pmi_pkg::pmi_tx_word_t tx_word,
    output logic tx_elec_idle,
    output logic tx_buf_pwrdn,
    output logic tx_beacon,
    output logic loopback_en,
    output pmi_pkg::pmi_gen2_ctl_t gen2_ctl,
    // analog receiver detect circuitry
    output logic det_start,
    input wire logic det_complete,
    input wire logic det_present
);

    // ---------------- apb slave ----------------
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic acc;
    logic hit_ctrl;
    logic hit_stat;
    logic wr_ctrl;
    logic [31:0] strb_mask;
    logic [31:0] stat_word;

    // byte lanes expanded to a bit mask
    function automatic logic [31:0] pmi_lane_mask(input logic [3:0] s);
        pmi_lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // decode; no wait states, so pready is simply high
    assign acc = psel & penable;
    assign hit_ctrl = (paddr == `PMI_OFS_CTRL);
    assign hit_stat = (paddr == `PMI_OFS_STAT);
    assign wr_ctrl = acc & pwrite & hit_ctrl;
    assign strb_mask = pmi_lane_mask(pstrb);
    assign ctrl_next = (ctrl_reg & ~strb_mask) | (pwdata & strb_mask);
    assign pready = 1'b1;
    assign pslverr = acc & ~(hit_ctrl | hit_stat);
    assign prdata = (psel & ~pwrite & hit_ctrl) ? ctrl_reg : (psel & ~pwrite & hit_stat) ? stat_word : 32'h0000_0000;

    // control register write
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `PMI_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= ctrl_next;
        end
    end

    // gen2 features vanish at gen1 so margin and de-emphasis never leak into a gen1 link
    pmi_pkg::pmi_gen2_ctl_t gen2_next;
    logic gen2_on;
    assign gen2_on = GEN2_CAPABLE & ctrl_reg[`PMI_CTRL_GEN2];
    assign gen2_next.gen2 = gen2_on;
    assign gen2_next.margin = gen2_on ? ctrl_reg[`PMI_CTRL_MARGIN_HI:`PMI_CTRL_MARGIN_LO] : 3'h0;
    assign gen2_next.deemph_6db = gen2_on & ctrl_reg[`PMI_CTRL_DEEMPH6];

    // ---------------- analog detect result crossing ----------------
    logic [1:0] det_sync;
    pmi_sync3 #(
        .WIDTH(2)
    ) u_det_sync (
        .clock(clock),
        .rst(rst),
        .async_in({det_present, det_complete}),
        .sync_out(det_sync)
    );

    logic det_cmpl_s;
    logic det_pres_s;
    logic det_cmpl_d_reg;
    logic det_cmpl_rise;
    assign det_cmpl_s = det_sync[0];
    assign det_pres_s = det_sync[1];
    assign det_cmpl_rise = det_cmpl_s & ~det_cmpl_d_reg;

    // ---------------- power state and request edges ----------------
    logic [1:0] ps_reg;
    logic ps_valid_reg;
    logic dl_d_reg;
    logic ps_change;
    logic in_p0;
    logic in_p0s;
    logic in_p1;
    logic in_p2;
    logic det_req;

    assign in_p0 = (power_sel == `PMI_PS_P0);
    assign in_p0s = (power_sel == `PMI_PS_P0S);
    assign in_p1 = (power_sel == `PMI_PS_P1);
    assign in_p2 = (power_sel == `PMI_PS_P2);
    // a change of select is a transition; the first value after reset is not
    assign ps_change = ps_valid_reg & (power_sel != ps_reg);
    // only a rising request in P1 starts detection; in P0 the input means loopback
    assign det_req = detect_loopback & ~dl_d_reg & in_p1;

    // ---------------- receiver detect sequencer ----------------
    pmi_pkg::pmi_det_state_t det_state_reg;
    pmi_pkg::pmi_det_state_t det_state_next;
    logic rx_found_reg;

    // start pulse, then wait for the analog result, then report it
    always_comb begin
        det_state_next = det_state_reg;
        case (det_state_reg)
            pmi_pkg::DET_IDLE: begin
                if (det_req) begin
                    det_state_next = pmi_pkg::DET_START;
                end
            end
            pmi_pkg::DET_START: begin
                det_state_next = pmi_pkg::DET_WAIT;
            end
            pmi_pkg::DET_WAIT: begin
                if (det_cmpl_rise) begin
                    det_state_next = pmi_pkg::DET_REPORT;
                end
            end
            pmi_pkg::DET_REPORT: begin
                det_state_next = pmi_pkg::DET_IDLE;
            end
            default: begin
                det_state_next = pmi_pkg::DET_IDLE;
            end
        endcase
    end

    // ---------------- transmitter state ----------------
    logic idle_req;
    logic idle_hold;
    // P0s and P1 always idle; P2 idles only under force_idle and otherwise releases idle for a beacon
    assign idle_req = force_idle | in_p0s | in_p1 | (in_p2 & force_idle);

    pmi_idle_hold #(
        .MIN_CYC(IDLE_MIN_CYC)
    ) u_idle_hold (
        .clock(clock),
        .rst(rst),
        .idle_req(idle_req),
        .idle_out(idle_hold)
    );

    logic done_next;
    logic [2:0] status_next;
    // a detect report owns the status code; a transition alone reports ok
    assign done_next = (det_state_reg == pmi_pkg::DET_REPORT) | ps_change;
    assign status_next = (det_state_reg == pmi_pkg::DET_REPORT) ?
        (rx_found_reg ? `PMI_ST_RX_FOUND : `PMI_ST_NO_RX) : `PMI_ST_OK;

    pmi_pkg::pmi_tx_word_t tx_word_next;
    assign tx_word_next.data = tx_data;
    assign tx_word_next.is_k = tx_is_k;
    assign tx_word_next.force_neg = force_disp;

    // status word for software
    assign stat_word = {26'h0, tx_word.force_neg & 1'b0 | gen2_ctl.gen2, rx_found_reg,
        (det_state_reg != pmi_pkg::DET_IDLE), tx_elec_idle, ps_reg};

    // sequencer, edge history and power state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            det_state_reg <= pmi_pkg::DET_IDLE;
            rx_found_reg <= 1'b0;
            det_cmpl_d_reg <= 1'b0;
            dl_d_reg <= 1'b0;
            ps_reg <= `PMI_PS_P0;
            ps_valid_reg <= 1'b0;
        end else begin
            det_state_reg <= det_state_next;
            if ((det_state_reg == pmi_pkg::DET_WAIT) && det_cmpl_rise) begin
                rx_found_reg <= det_pres_s;
            end
            det_cmpl_d_reg <= det_cmpl_s;
            dl_d_reg <= detect_loopback;
            ps_reg <= power_sel;
            ps_valid_reg <= 1'b1;
        end
    end

    // registered outputs; data, force flag and idle stay aligned by one cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
            status <= `PMI_ST_OK;
            det_start <= 1'b0;
            tx_word <= '0;
            tx_elec_idle <= 1'b1;
            tx_buf_pwrdn <= 1'b0;
            tx_beacon <= 1'b0;
            loopback_en <= 1'b0;
            gen2_ctl <= '0;
        end else begin
            done <= done_next;
            status <= status_next;
            det_start <= (det_state_next == pmi_pkg::DET_START);
            tx_word <= tx_word_next;
            tx_elec_idle <= idle_hold;
            tx_buf_pwrdn <= in_p1;
            tx_beacon <= in_p2 & ~force_idle & ~idle_hold;
            loopback_en <= in_p0 & detect_loopback;
            gen2_ctl <= gen2_next;
        end
    end

endmodule // pmi_ctrl

/* rtl/pmi_defines.svh */
// Purpose: shared offsets, field positions, reset values and timing counts of the phy-mac interface control
// Assumes: 32-bit apb data, one aligned word per register
// Notes: definitions only
`ifndef PMI_DEFINES_SVH
`define PMI_DEFINES_SVH

// power-state select codes
`define PMI_PS_P0 2'h0
`define PMI_PS_P0S 2'h1
`define PMI_PS_P1 2'h2
`define PMI_PS_P2 2'h3

// status codes on the status output
`define PMI_ST_OK 3'h0
`define PMI_ST_NO_RX 3'h1
`define PMI_ST_RX_FOUND 3'h3

// register byte offsets
`define PMI_OFS_CTRL 12'h000
`define PMI_OFS_STAT 12'h004

// control register fields
`define PMI_CTRL_GEN2 0
`define PMI_CTRL_MARGIN_LO 1
`define PMI_CTRL_MARGIN_HI 3
`define PMI_CTRL_DEEMPH6 4
`define PMI_CTRL_RESET 32'h0000_0000

// status register fields
`define PMI_STAT_PS_LO 0
`define PMI_STAT_PS_HI 1
`define PMI_STAT_IDLE 2
`define PMI_STAT_DET_BUSY 3
`define PMI_STAT_RX_FOUND 4
`define PMI_STAT_GEN2 5

// minimum electrical idle residency
`define PMI_IDLE_MIN_NS 20
`define PMI_CLK_PERIOD_PS 4000
`define PMI_IDLE_MIN_CYC ((`PMI_IDLE_MIN_NS * 1000 + `PMI_CLK_PERIOD_PS - 1) / `PMI_CLK_PERIOD_PS)

`endif

/* rtl/pmi_idle_hold.sv */
// Purpose: stretches an electrical idle request to a minimum residency
// Assumes: idle_req is synchronous to clock
// Notes: idle_out is combinational on idle_req; the caller registers it
`timescale 1ns/1ps
`include "pmi_defines.svh"
module pmi_idle_hold #(
    parameter int MIN_CYC = `PMI_IDLE_MIN_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // request and stretched result
    input wire logic idle_req,
    output logic idle_out
);

    localparam int CW = $clog2(MIN_CYC + 1);
    localparam logic [CW-1:0] MIN_C = CW'(MIN_CYC);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic holding;

    // once idle has begun it is kept until MIN_CYC idle cycles have passed
    assign holding = (cnt_reg != '0) && (cnt_reg < MIN_C);
    assign idle_out = idle_req | holding;
    assign cnt_next = !idle_out ? '0 : (cnt_reg < MIN_C) ? cnt_reg + CW'(1) : cnt_reg;

    // residency counter
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule // pmi_idle_hold

/* rtl/pmi_pkg.sv */
// Purpose: types of the phy-mac interface control
// Assumes: 16-bit parallel transmit path at most
// Notes: constants live in pmi_defines.svh
package pmi_pkg;

    // receiver detect sequencer, one-hot
    typedef enum logic [3:0] {
        DET_IDLE = 4'b0001,
        DET_START = 4'b0010,
        DET_WAIT = 4'b0100,
        DET_REPORT = 4'b1000
    } pmi_det_state_t;

    // parallel transmit word handed to the encoder
    typedef struct packed {
        logic [15:0] data;
        logic [1:0] is_k;
        logic force_neg;
    } pmi_tx_word_t;

    // gen2-only transmitter controls
    typedef struct packed {
        logic gen2;
        logic [2:0] margin;
        logic deemph_6db;
    } pmi_gen2_ctl_t;

endpackage

/* rtl/pmi_sync3.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs are levels from outside the clock domain
// Notes: the first stage is read only by the second
`timescale 1ns/1ps
module pmi_sync3 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // async side
    input wire logic [WIDTH-1:0] async_in,
    // synchronous side
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] agree;

    // a bit changes only once stages two and three agree
    assign agree = ~(s2_reg ^ s3_reg);

    // shift chain and filtered output
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            out_reg <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= (agree & s3_reg) | (~agree & out_reg);
        end
    end

    assign sync_out = out_reg;

endmodule // pmi_sync3

/* test/pmi_ctrl_properties.sv */
// Purpose: port-level checks of pmi_ctrl
// Assumes: power_sel is steady across reset release
// Notes: bound into pmi_ctrl below
`timescale 1ns/1ps
`include "pmi_defines.svh"
module pmi_ctrl_properties #(
    parameter int IDLE_MIN_CYC = 5
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // mac side
    input wire logic [1:0] power_sel,
    input wire logic force_idle,
    input wire logic detect_loopback,
    input wire logic force_disp,
    input wire logic [15:0] tx_data,
    input wire logic done,
    input wire logic [2:0] status,
    // transmitter side
    input wire pmi_pkg::pmi_tx_word_t tx_word,
    input wire logic tx_elec_idle,
    input wire logic tx_buf_pwrdn,
    input wire logic tx_beacon,
    input wire logic loopback_en,
    input wire pmi_pkg::pmi_gen2_ctl_t gen2_ctl,
    input wire logic det_start
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    int idle_cnt_reg;
    // idle run length; starts full so the reset-time idle is not judged
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            idle_cnt_reg <= IDLE_MIN_CYC;
        end else begin
            idle_cnt_reg <= tx_elec_idle ? idle_cnt_reg + 1 : 0;
        end
    end
    property p_force_idle; force_idle |=> tx_elec_idle; endproperty
    a_force_idle: assert property (p_force_idle) else $error("idle not forced");
    property p_idle_min; $fell(tx_elec_idle) |-> idle_cnt_reg >= IDLE_MIN_CYC; endproperty
    a_idle_min: assert property (p_idle_min) else $error("idle too short");
    property p_p1_idle; power_sel == `PMI_PS_P1 |=> tx_elec_idle && tx_buf_pwrdn; endproperty
    a_p1_idle: assert property (p_p1_idle) else $error("p1 not idle");
    property p_p0s_idle; power_sel == `PMI_PS_P0S |=> tx_elec_idle && !tx_beacon; endproperty
    a_p0s_idle: assert property (p_p0s_idle) else $error("p0s not idle");
    property p_det_start;
        det_start |-> $past(power_sel) == `PMI_PS_P1 && $past(detect_loopback) && !$past(detect_loopback, 2);
    endproperty
    a_det_start: assert property (p_det_start) else $error("stray detect start");
    property p_done_once; done && status != `PMI_ST_OK |=> !done && status == `PMI_ST_OK; endproperty
    a_done_once: assert property (p_done_once) else $error("detect report too long");
    property p_status_ok; !done |-> status == `PMI_ST_OK; endproperty
    a_status_ok: assert property (p_status_ok) else $error("status without done");
    property p_power_done; power_sel != $past(power_sel) |=> done; endproperty
    a_power_done: assert property (p_power_done) else $error("no done on transition");
    property p_gen2_only; !gen2_ctl.gen2 |-> gen2_ctl == 5'h00; endproperty
    a_gen2_only: assert property (p_gen2_only) else $error("gen2 control without gen2");
    property p_tx_word; 1'b1 |=> tx_word.data == $past(tx_data) && tx_word.force_neg == $past(force_disp); endproperty
    a_tx_word: assert property (p_tx_word) else $error("tx word mismatch");
    property p_loopback; loopback_en |-> $past(power_sel) == `PMI_PS_P0 && $past(detect_loopback); endproperty
    a_loopback: assert property (p_loopback) else $error("loopback outside p0");
    property p_beacon; tx_beacon |-> $past(power_sel) == `PMI_PS_P2 && !$past(force_idle); endproperty
    a_beacon: assert property (p_beacon) else $error("beacon outside p2");
endmodule // pmi_ctrl_properties

bind pmi_ctrl pmi_ctrl_properties #(.IDLE_MIN_CYC(IDLE_MIN_CYC)) u_props (.clock, .rst, .power_sel, .force_idle,
    .detect_loopback, .force_disp, .tx_data, .done, .status, .tx_word, .tx_elec_idle, .tx_buf_pwrdn, .tx_beacon,
    .loopback_en, .gen2_ctl, .det_start);

/* test/pmi_det_model.sv */
// Purpose: behavioural far-end receiver detect circuitry
// Assumes: det_start is a short pulse
// Notes: results hold until the next start
`timescale 1ns/1ps
module pmi_det_model (
    // start from the control block
    input wire logic det_start,
    // knobs: far end present, answer delay in reference cycles
    input wire logic present,
    input wire logic [3:0] lag,
    // result levels
    output logic det_complete,
    output logic det_present
);
    logic fixedclk = 1'b0;
    // 125 MHz detect reference, unrelated in phase to the parallel clock
    initial forever #4 fixedclk = ~fixedclk;
    initial begin
        det_complete = 1'b0;
        det_present = 1'b0;
    end
    // a start clears the old result; present shows junk until the answer
    always @(posedge det_start) begin
        det_complete <= 1'b0;
        det_present <= ~present;
        repeat (lag + 1) @(posedge fixedclk);
        det_complete <= 1'b1;
        det_present <= present;
    end
endmodule // pmi_det_model

/* test/test_pmi_ctrl.sv */
// Purpose: self-checking bench of pmi_ctrl
// Assumes: detect answers come from pmi_det_model
// Notes: random traffic from a 32-bit lfsr
`timescale 1ns/1ps
`include "pmi_defines.svh"
module test_pmi_ctrl;
    localparam int IMC = 5;
    logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, force_idle = 0, dl = 0, force_disp = 0;
    logic pready, pslverr, done, tx_elec_idle, tx_buf_pwrdn, tx_beacon, loopback_en, det_start, err;
    logic det_complete, det_present, present = 0, cp = 0, cp_tog = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, w, lfsr = 32'h0001_22D7;
    logic [15:0] tx_data = 0;
    logic [1:0] tx_is_k = 0, power_sel = `PMI_PS_P0;
    logic [2:0] status, st;
    logic [3:0] lag = 0;
    pmi_pkg::pmi_tx_word_t tx_word;
    pmi_pkg::pmi_gen2_ctl_t gen2_ctl;
    integer fails = 0, num_checks = 0, n, i;
    logic [18:0] q[$];
    pmi_ctrl #(.GEN2_CAPABLE(1'b1), .IDLE_MIN_CYC(IMC)) DUT (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hF), .prdata, .pready, .pslverr, .power_sel, .force_idle, .detect_loopback(dl), .force_disp,
        .tx_data, .tx_is_k, .done, .status, .tx_word, .tx_elec_idle, .tx_buf_pwrdn, .tx_beacon, .loopback_en,
        .gen2_ctl, .det_start, .det_complete, .det_present);
    pmi_det_model u_det (.det_start, .present, .lag, .det_complete, .det_present);
    initial forever #2 clock = ~clock;
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one apb transfer; read data taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge clock);
        penable <= 1;
        for (n = 0; n < 50; n++) begin @(posedge clock); if (pready === 1'b1) break; end
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
        if (n == 50) begin fails++; give_verdict(); end
    endtask
    // waits for done, then done and status must drop the next cycle
    task automatic wait_done;
        for (n = 0; n < 300; n++) begin @(posedge clock); if (done === 1'b1) break; end
        st = status;
        @(posedge clock);
        check(32'(done), 0);
        check(32'(status), `PMI_ST_OK);
        if (n == 300) begin fails++; give_verdict(); end
    endtask
    task automatic set_ps(input logic [1:0] ps, input logic fi);
        @(posedge clock);
        power_sel <= ps; force_idle <= fi;
        wait_done();
        check(32'(st), `PMI_ST_OK);
        repeat (8) @(posedge clock);
        check(32'(tx_elec_idle), 32'(ps != `PMI_PS_P0 || fi));
        check(32'(tx_buf_pwrdn), 32'(ps == `PMI_PS_P1));
    endtask
    // transmit stream: compliance pair with forced disparity on request, else random
    // the 16-bit lane carries both bytes of a pair, so the 8-bit rule is not exercised here
    always @(posedge clock) begin
        lfsr <= lfsr_step(lfsr);
        cp_tog <= cp & ~cp_tog;
        if (cp) {tx_data, tx_is_k, force_disp} <= cp_tog ? {16'h4ABC, 2'h1, 1'b0} : {16'hB5BC, 2'h1, 1'b1};
        else {tx_data, tx_is_k, force_disp} <= lfsr[18:0];
    end
    // reference model: each tx word is the previous cycle's inputs
    always @(posedge clock) begin
        if (rst) q.delete();
        else begin
            q.push_back({tx_data, tx_is_k, force_disp});
            if (q.size() > 1) check(32'(tx_word), 32'(q.pop_front()));
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        check(32'(tx_elec_idle), 1);
        check(32'({done, status}), 0);
        rst <= 0;
        // registers: reset value, random writes, read-only and unmapped places
        apb(0, `PMI_OFS_CTRL, 0);
        check(rd, `PMI_CTRL_RESET);
        for (i = 0; i < 4; i++) begin
            w = lfsr;
            apb(1, `PMI_OFS_CTRL, w);
            apb(0, `PMI_OFS_CTRL, 0);
            check(32'(rd[4:0]), 32'(w[4:0]));
            check(32'(gen2_ctl), w[0] ? 32'({w[0], w[3:1], w[4]}) : 0);
        end
        apb(1, `PMI_OFS_STAT, 32'hFFFF_FFFF);
        apb(0, `PMI_OFS_STAT, 0);
        check(32'({err, rd[1:0]}), 32'(`PMI_PS_P0));
        apb(0, 12'h008, 0);
        check(32'(err), 1);
        cp <= 1;
        repeat (4) @(posedge clock);
        cp <= 0;
        // power states in turn; detect only while in P1
        set_ps(`PMI_PS_P0S, 1);
        set_ps(`PMI_PS_P1, 1);
        for (i = 0; i < 2; i++) begin
            present <= ~i[0];
            lag <= i ? 4'h9 : 4'h1;
            @(posedge clock);
            dl <= 1;
            wait_done();
            check(32'(st), i ? `PMI_ST_NO_RX : `PMI_ST_RX_FOUND);
            dl <= 0;
        end
        set_ps(`PMI_PS_P2, 1);
        force_idle <= 0;
        repeat (8) @(posedge clock);
        check(32'(tx_beacon), 1);
        set_ps(`PMI_PS_P0, 0);
        dl <= 1;
        repeat (3) @(posedge clock);
        check(32'({loopback_en, det_start}), 2);
        dl <= 0;
        // a one-cycle force-idle still yields the minimum idle residency
        force_idle <= 1;
        @(posedge clock);
        force_idle <= 0;
        n = 0;
        for (i = 0; i < 30; i++) begin @(posedge clock); n += tx_elec_idle; end
        check(32'(n >= IMC), 1);
        give_verdict();
    end
endmodule // test_pmi_ctrl
